// ---- core/dual_mode_serial_port.sv ----
// Purpose: Two-channel serial port, asynchronous / clocked synchronous / smart card, AHB-Lite slave
// Assumes: sys_clk 10 MHz, synchronous active-low resetn, pins asynchronous to sys_clk
// Notes:   Overview of operation below
//
// Overview of operation
// R01: Two channels, each with its own registers and pins, fully independent.
// R02: Transmitter and receiver of a channel run at the same time.
// R03: Software picks LSB or MSB first, except seven-bit asynchronous characters; card mode takes the order from the convention bit instead.
// R04: Each channel raises transmit-end, transmit-empty, receive-full and receive-error requests.
// R05: Only transmit-empty and receive-full also act as DMA triggers.
// R06: Asynchronous characters are seven or eight data bits.
// R07: Asynchronous frames carry one or two stop bits.
// R08: Asynchronous parity is even, odd or none.
// R09: Asynchronous receiver flags parity, overrun and framing errors.
// R10: Software can read the live receive pin level.
// R11: Synchronous mode uses eight bits and flags only overrun.
// R12: Smart card receiver drives an error signal on parity error.
// R13: Smart card transmitter resends a character when the card signals error.
// R14: Smart card supports direct and inverse convention.
// R15: Clock from internal generator or clock pin; clock pin not in card mode.
// R16: Each channel has a two-way clock pin, receive input and transmit output.
// R17: Receive shifter assembles a frame, then copies it into the receive buffer.
// R18: Receive buffer is eight bits, resets to zero, read only.
// R19: Software reads the receive buffer once per character after receive-full.
// R20: An empty transmit shifter takes the transmit buffer and starts sending.
// R21: A waiting character is loaded at frame end with no gap.
// R22: Software writes the transmit buffer once after transmit-empty.
// R23: Seven-bit asynchronous sends LSB first and omits buffer bit seven.
// R24: Receiver checks only the first stop bit; low second stop starts a frame.
// R25: Parity mode zero is even, one is odd.
// R26: Transmit-empty sets on load to shifter; receive-full sets on buffer landing.
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns

module serial_channel
	import serial_port_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// Register access
	input  wire logic       wr_en,
	input  wire logic [2:0] wr_idx,
	input  wire logic [7:0] wr_data,
	input  wire logic       rd_take,
	input  wire logic [2:0] rd_idx,
	output logic      [7:0] rd_data,
	// Pins
	input  wire logic       rxd_pin,
	input  wire logic       sck_in,
	output logic            sck_out,
	output logic            sck_oe,
	output logic            txd_out,
	// Requests
	output logic      [3:0] req,
	output logic      [1:0] dma_req
);

	// ==========================================================================
	// Configuration registers
	logic [7:0] format_q, format_d, control_q, control_d, card_q, card_d;
	logic [7:0] divisor_q, divisor_d, tx_buf_q, tx_buf_d;
	logic       tx_buf_wr, status_wr, rx_buf_read;

	always_comb
	begin
		format_d  = format_q;
		control_d = control_q;
		card_d    = card_q;
		divisor_d = divisor_q;
		tx_buf_d  = tx_buf_q;
		if (wr_en)
		begin
			case (wr_idx)
				REG_FORMAT:  format_d  = wr_data;
				REG_CONTROL: control_d = wr_data;
				REG_CARD:    card_d    = wr_data;
				REG_DIVISOR: divisor_d = wr_data;
				REG_TX_BUF:  tx_buf_d  = wr_data; // R22
				default:     ; // R18
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			format_q  <= FORMAT_RESET;
			control_q <= CONTROL_RESET;
			card_q    <= CARD_RESET;
			divisor_q <= DIVISOR_RESET;
			tx_buf_q  <= TX_BUF_RESET;
		end
		else
		begin
			format_q  <= format_d;
			control_q <= control_d;
			card_q    <= card_d;
			divisor_q <= divisor_d;
			tx_buf_q  <= tx_buf_d;
		end
	end

	assign tx_buf_wr   = wr_en && (wr_idx == REG_TX_BUF);
	assign status_wr   = wr_en && (wr_idx == REG_STATUS);
	assign rx_buf_read = rd_take && (rd_idx == REG_RX_BUF);

	// Mode decode
	logic card_sel, sync_mode, char7, par_en, par_odd, two_stop, msb_first, line_inv, ext_clk, tx_en, rx_en;
	assign card_sel  = card_q[CARD_SELECT];
	assign sync_mode = format_q[FMT_SYNC] & ~card_sel;
	assign char7     = format_q[FMT_CHAR7] & ~sync_mode & ~card_sel;              // R06 R11
	assign par_en    = (format_q[FMT_PAR_EN] & ~sync_mode) | card_sel;            // R08 R11
	assign par_odd   = format_q[FMT_PAR_ODD];                                     // R25
	assign two_stop  = format_q[FMT_TWO_STOP] | card_sel;                         // R07
	assign line_inv  = card_sel & card_q[CARD_INVERSE];                           // R14
	assign msb_first = card_sel ? line_inv : (format_q[FMT_MSB_FIRST] & ~char7); // R03 R23
	assign ext_clk   = control_q[CTL_EXT_CLK] & ~card_sel;                        // R15
	assign tx_en     = control_q[CTL_TX_EN];
	assign rx_en     = control_q[CTL_RX_EN];

	// ==========================================================================
	// Pin synchronisers and bit clock
	logic [1:0] rxd_sync_q, sck_sync_q;
	logic       sck_prev_q, sck_q, sck_d;
	logic [7:0] div_q, div_d;
	logic       rxd_s, int_tick, tick, rise_evt, fall_evt, clk_run;
	logic       tx_busy, rx_full_q, tx_empty_q;

	assign rxd_s    = rxd_sync_q[1];
	assign int_tick = (div_q == divisor_q);
	assign tick     = ext_clk ? (sck_sync_q[1] & ~sck_prev_q) : int_tick;      // R15
	assign clk_run  = sync_mode & (tx_busy | (rx_en & ~rx_full_q));
	assign rise_evt = ext_clk ? (sck_sync_q[1] & ~sck_prev_q) : (int_tick & clk_run & ~sck_q);
	assign fall_evt = ext_clk ? (~sck_sync_q[1] & sck_prev_q) : (int_tick & clk_run & sck_q);

	always_comb
	begin
		div_d = int_tick ? 8'h00 : div_q + 8'h01;
		sck_d = sck_q;
		if (!clk_run || ext_clk)
			sck_d = 1'b1;
		else if (int_tick)
			sck_d = ~sck_q;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			rxd_sync_q <= 2'h3;
			sck_sync_q <= 2'h3;
			sck_prev_q <= 1'b1;
			sck_q      <= 1'b1;
			div_q      <= 8'h00;
		end
		else
		begin
			rxd_sync_q <= {rxd_sync_q[0], rxd_pin};
			sck_sync_q <= {sck_sync_q[0], sck_in};
			sck_prev_q <= sck_sync_q[1];
			sck_q      <= sck_d;
			div_q      <= div_d;
		end
	end

	assign sck_out = sck_q;                   // R16
	assign sck_oe  = sync_mode & ~ext_clk;    // R16

	// ==========================================================================
	// Transmitter
	tx_state_type       tx_state_q, tx_state_d;
	logic [FRAME_W-1:0] frame_q, frame_d, frame_new;
	logic [3:0]         tx_left_q, tx_left_d, tx_tick_q, tx_tick_d, nbits_new;
	logic [7:0]         tx_data_q, tx_data_d, load_src, src7, ord;
	logic               tx_pend_q, tx_pend_d, tx_err_q, tx_err_d, par_line, tx_retry;
	logic               count_now, shift_now, tx_done, load_ok, tx_load, start_frame, errsig;

	always_comb
	begin
		tx_retry = card_sel & tx_err_q;
		load_src = tx_retry ? tx_data_q : tx_buf_q;
		src7     = char7 ? {1'b0, load_src[6:0]} : load_src;
		ord      = line_order(load_src, msb_first, line_inv);
		par_line = par_en ? (^src7 ^ par_odd ^ line_inv) : 1'b1;                 // R08 R25
		if (sync_mode)
		begin
			frame_new = {5'h1F, ord};                                             // R11
			nbits_new = DATA8;
		end
		else
		begin
			frame_new = char7 ? {4'hF, par_line, ord[6:0], 1'b0} : {3'h7, par_line, ord, 1'b0}; // R23
			nbits_new = 4'h1 + (char7 ? DATA7 : DATA8) + {3'h0, par_en} + (two_stop ? 4'h2 : 4'h1); // R07
		end
	end

	always_comb
	begin
		tx_busy     = (tx_state_q == TX_SEND);
		count_now   = sync_mode ? rise_evt : (tick && tx_tick_q == TICK_LAST);
		shift_now   = sync_mode ? (fall_evt & tx_pend_q) : count_now;
		tx_done     = tx_busy && count_now && (tx_left_q == 4'h1);
		load_ok     = tx_en & ~tx_empty_q & ~tx_buf_wr;
		start_frame = (!tx_busy && load_ok) || (tx_done && (tx_retry || load_ok)); // R20 R21 R13
		tx_load     = start_frame & ~tx_retry;                                    // R26
		tx_state_d  = tx_state_q;
		frame_d     = frame_q;
		tx_left_d   = tx_left_q;
		tx_tick_d   = tx_tick_q;
		tx_data_d   = tx_data_q;
		tx_pend_d   = tx_pend_q;
		tx_err_d    = tx_err_q;
		if (tx_busy)
		begin
			if (tick && !sync_mode)
				tx_tick_d = tx_tick_q + 4'h1;
			if (rise_evt)
				tx_pend_d = 1'b1;
			else if (fall_evt)
				tx_pend_d = 1'b0;
			if (shift_now)
				frame_d = {1'b1, frame_q[FRAME_W-1:1]};
			if (count_now)
				tx_left_d = tx_left_q - 4'h1;
			if (card_sel && tick && tx_tick_q == TICK_CHECK && tx_left_q == 4'h2 && !rxd_s)
				tx_err_d = 1'b1;                                                  // R13
			if (tx_done)
				tx_state_d = TX_IDLE;
		end
		if (start_frame)
		begin
			tx_state_d = TX_SEND;
			frame_d    = frame_new;
			tx_left_d  = nbits_new;
			tx_tick_d  = 4'h0;
			tx_pend_d  = 1'b0;
			tx_err_d   = 1'b0;
			tx_data_d  = load_src;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			tx_state_q <= TX_IDLE;
			frame_q    <= '1;
			tx_left_q  <= 4'h0;
			tx_tick_q  <= 4'h0;
			tx_data_q  <= 8'h00;
			tx_pend_q  <= 1'b0;
			tx_err_q   <= 1'b0;
		end
		else
		begin
			tx_state_q <= tx_state_d;
			frame_q    <= frame_d;
			tx_left_q  <= tx_left_d;
			tx_tick_q  <= tx_tick_d;
			tx_data_q  <= tx_data_d;
			tx_pend_q  <= tx_pend_d;
			tx_err_q   <= tx_err_d;
		end
	end

	assign txd_out = (tx_busy ? frame_q[0] : 1'b1) & ~errsig;                     // R12

	// ==========================================================================
	// Receiver
	rx_state_type    rx_state_q, rx_state_d;
	logic [RX_W-1:0] rx_shift_q, rx_shift_d, aligned;
	logic [3:0]      rx_left_q, rx_left_d, rx_tick_q, rx_tick_d, rx_nbits, shamt;
	logic [7:0]      rx_word;
	logic            rx_sample, rx_complete, perr, ferr;

	always_comb
	begin
		rx_nbits    = sync_mode ? DATA8 : ((char7 ? DATA7 : DATA8) + {3'h0, par_en} + 4'h1); // R24
		rx_sample   = sync_mode ? rise_evt : (tick && rx_tick_q == TICK_LAST);
		rx_state_d  = rx_state_q;
		rx_shift_d  = rx_shift_q;
		rx_left_d   = rx_left_q;
		rx_tick_d   = rx_tick_q;
		rx_complete = 1'b0;
		if (tick && rx_state_q != RX_IDLE)
			rx_tick_d = rx_tick_q + 4'h1;
		case (rx_state_q)
			RX_IDLE:
			begin
				rx_tick_d = 4'h0;
				rx_left_d = rx_nbits;
				if (rx_en && sync_mode)
					rx_state_d = RX_BITS;
				else if (rx_en && tick && !rxd_s)
					rx_state_d = RX_START;
			end
			RX_START:
				if (tick && rx_tick_q == TICK_MID)
				begin
					rx_tick_d  = 4'h0;
					rx_state_d = rxd_s ? RX_IDLE : RX_BITS;
				end
			RX_BITS:
				if (rx_sample)
				begin
					rx_shift_d = {rxd_s, rx_shift_q[RX_W-1:1]};                   // R17
					rx_left_d  = rx_left_q - 4'h1;
					if (rx_left_q == 4'h1)
					begin
						rx_complete = 1'b1;
						rx_tick_d   = 4'h0;
						rx_left_d   = rx_nbits;
						rx_state_d  = RX_IDLE;
					end
				end
			RX_ERRSIG:
				if (tick && rx_tick_q == TICK_LAST)
					rx_state_d = RX_IDLE;
			default:
				rx_state_d = RX_IDLE;
		endcase
		shamt   = RX_W - rx_nbits;
		aligned = rx_shift_d >> shamt;
		rx_word = line_order(char7 ? {1'b0, aligned[6:0]} : aligned[7:0], msb_first, line_inv); // R03 R14
		perr    = par_en & (^rx_word ^ rx_shift_d[RX_W-2] ^ line_inv ^ par_odd);  // R09 R25
		ferr    = ~sync_mode & ~card_sel & ~rx_shift_d[RX_W-1];                   // R09
		if (rx_complete && card_sel && perr)
			rx_state_d = RX_ERRSIG;                                               // R12
		if (!rx_en)
			rx_state_d = RX_IDLE;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			rx_state_q <= RX_IDLE;
			rx_shift_q <= '0;
			rx_left_q  <= 4'h0;
			rx_tick_q  <= 4'h0;
		end
		else
		begin
			rx_state_q <= rx_state_d;
			rx_shift_q <= rx_shift_d;
			rx_left_q  <= rx_left_d;
			rx_tick_q  <= rx_tick_d;
		end
	end

	assign errsig = (rx_state_q == RX_ERRSIG);

	// ==========================================================================
	// Buffers and status flags; a set in the same cycle as its clear wins
	logic [7:0] rx_buf_q, rx_buf_d;
	logic       rx_full_d, tx_empty_d, ovr_q, ovr_d, fer_q, fer_d, per_q, per_d, full_eff, tx_end;

	always_comb
	begin
		full_eff   = rx_full_q & ~rx_buf_read;
		rx_buf_d   = (rx_complete && !full_eff) ? rx_word : rx_buf_q;                       // R17
		rx_full_d  = (rx_complete & ~full_eff & ~(perr & ~sync_mode) & ~ferr) | full_eff;     // R26
		tx_empty_d = tx_load | (tx_empty_q & ~tx_buf_wr);                                    // R26
		ovr_d      = (rx_complete & full_eff) | (ovr_q & ~(status_wr & ~wr_data[ST_OVERRUN])); // R09 R11
		fer_d      = (rx_complete & ~full_eff & ferr) | (fer_q & ~(status_wr & ~wr_data[ST_FRAMING]));
		per_d      = (rx_complete & ~full_eff & perr & ~sync_mode)
			| (per_q & ~(status_wr & ~wr_data[ST_PARITY]));
		tx_end     = tx_en & ~tx_busy & tx_empty_q;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			rx_buf_q   <= RX_BUF_RESET;  // R18
			rx_full_q  <= 1'b0;
			tx_empty_q <= 1'b1;
			ovr_q      <= 1'b0;
			fer_q      <= 1'b0;
			per_q      <= 1'b0;
		end
		else
		begin
			rx_buf_q   <= rx_buf_d;
			rx_full_q  <= rx_full_d;
			tx_empty_q <= tx_empty_d;
			ovr_q      <= ovr_d;
			fer_q      <= fer_d;
			per_q      <= per_d;
		end
	end

	always_comb
	begin
		rd_data = 8'h00;
		case (rd_idx)
			REG_FORMAT:  rd_data = format_q;
			REG_CONTROL: rd_data = control_q;
			REG_STATUS:
			begin
				rd_data[ST_TX_EMPTY]  = tx_empty_q;
				rd_data[ST_RX_FULL]   = rx_full_q;
				rd_data[ST_OVERRUN]   = ovr_q;
				rd_data[ST_FRAMING]   = fer_q;
				rd_data[ST_PARITY]    = per_q;
				rd_data[ST_TX_END]    = tx_end;
				rd_data[ST_RXD_LEVEL] = rxd_s;   // R10
			end
			REG_RX_BUF:  rd_data = rx_buf_q;
			REG_TX_BUF:  rd_data = tx_buf_q;
			REG_CARD:    rd_data = card_q;
			REG_DIVISOR: rd_data = divisor_q;
			default:     rd_data = 8'h00;
		endcase
	end

	// Request order: transmit-end, transmit-empty, receive-full, receive-error
	assign req[0]  = control_q[CTL_TEI_EN] & tx_end;                      // R04
	assign req[1]  = control_q[CTL_TXI_EN] & tx_en & tx_empty_q;          // R04
	assign req[2]  = control_q[CTL_RXI_EN] & rx_full_q;                   // R04
	assign req[3]  = control_q[CTL_RXI_EN] & (ovr_q | fer_q | per_q);     // R04
	assign dma_req = {req[2], req[1]};                                     // R05

endmodule // serial_channel

module dual_mode_serial_port
	import serial_port_pkg::*;
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  resetn,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic      [31:0]           hrdata,
	// Serial pins, one bit per channel
	input  wire logic [CHAN_COUNT-1:0] rxd_pin,
	input  wire logic [CHAN_COUNT-1:0] sck_in,
	output logic      [CHAN_COUNT-1:0] sck_out,
	output logic      [CHAN_COUNT-1:0] sck_oe,
	output logic      [CHAN_COUNT-1:0] txd_out,
	// Requests: four per channel, two DMA triggers per channel
	output logic      [CHAN_COUNT-1:0][3:0] irq_req,
	output logic      [CHAN_COUNT-1:0][1:0] dma_req
);

	// ==========================================================================
	// Bus slave: writes land at the end of the data phase, reads take one wait state
	logic        wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d, mapped_q, mapped_d, chan_q, chan_d;
	logic [2:0]  idx_q, idx_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic [7:0]  chan_rd [CHAN_COUNT];
	logic        accept;

	always_comb
	begin
		accept    = hsel & htrans[1] & hready;
		wr_pend_d = 1'b0;
		rd_pend_d = 1'b0;
		mapped_d  = mapped_q;
		chan_d    = chan_q;
		idx_d     = idx_q;
		hrdata_d  = hrdata_q;
		if (accept)
		begin
			mapped_d  = (haddr[31:MAP_TOP] == '0) && (haddr[IDX_MSB:IDX_LSB] <= REG_DIVISOR);
			chan_d    = haddr[CHAN_BIT];
			idx_d     = haddr[IDX_MSB:IDX_LSB];
			wr_pend_d = hwrite;
			rd_pend_d = ~hwrite;
		end
		if (rd_pend_q)
			hrdata_d = mapped_q ? {24'h00_0000, chan_rd[chan_q]} : 32'h0000_0000;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			mapped_q  <= 1'b0;
			chan_q    <= 1'b0;
			idx_q     <= 3'h0;
			hrdata_q  <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_q <= wr_pend_d;
			rd_pend_q <= rd_pend_d;
			mapped_q  <= mapped_d;
			chan_q    <= chan_d;
			idx_q     <= idx_d;
			hrdata_q  <= hrdata_d;
		end
	end

	assign hreadyout = ~rd_pend_q;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	// ==========================================================================
	// Channels
	for (genvar c = 0; c < CHAN_COUNT; c++)
	begin : g_chan
		serial_channel u_chan (                                              // R01 R02
			.sys_clk (sys_clk),
			.resetn  (resetn),
			.wr_en   (wr_pend_q && mapped_q && (chan_q == 1'(c))),
			.wr_idx  (idx_q),
			.wr_data (hwdata[7:0]),
			.rd_take (rd_pend_q && mapped_q && (chan_q == 1'(c))),
			.rd_idx  (idx_q),
			.rd_data (chan_rd[c]),
			.rxd_pin (rxd_pin[c]),
			.sck_in  (sck_in[c]),
			.sck_out (sck_out[c]),
			.sck_oe  (sck_oe[c]),
			.txd_out (txd_out[c]),
			.req     (irq_req[c]),
			.dma_req (dma_req[c])
		);
	end

endmodule // dual_mode_serial_port

// ---- core/serial_port_pkg.sv ----
// Purpose: Shared constants, register map, field layout and state types of the serial port
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers, two channels
// Notes:   Registers of a channel sit in one 32-byte window, channel chosen by address bit 5
package serial_port_pkg;

	// ==========================================================================
	// Register map
	localparam int         CHAN_COUNT     = 2;
	localparam int         CHAN_BIT       = 5;
	localparam int         IDX_MSB        = 4;
	localparam int         IDX_LSB        = 2;
	localparam int         MAP_TOP        = 6;
	localparam logic [2:0] REG_FORMAT     = 3'h0;
	localparam logic [2:0] REG_CONTROL    = 3'h1;
	localparam logic [2:0] REG_STATUS     = 3'h2;
	localparam logic [2:0] REG_RX_BUF     = 3'h3;
	localparam logic [2:0] REG_TX_BUF     = 3'h4;
	localparam logic [2:0] REG_CARD       = 3'h5;
	localparam logic [2:0] REG_DIVISOR    = 3'h6;

	// ==========================================================================
	// Field positions
	localparam int         FMT_SYNC       = 7;
	localparam int         FMT_CHAR7      = 6;
	localparam int         FMT_PAR_EN     = 5;
	localparam int         FMT_PAR_ODD    = 4;
	localparam int         FMT_TWO_STOP   = 3;
	localparam int         FMT_MSB_FIRST  = 2;
	localparam int         CTL_TXI_EN     = 7;
	localparam int         CTL_RXI_EN     = 6;
	localparam int         CTL_TX_EN      = 5;
	localparam int         CTL_RX_EN      = 4;
	localparam int         CTL_TEI_EN     = 2;
	localparam int         CTL_EXT_CLK    = 0;
	localparam int         ST_TX_EMPTY    = 7;
	localparam int         ST_RX_FULL     = 6;
	localparam int         ST_OVERRUN     = 5;
	localparam int         ST_FRAMING     = 4;
	localparam int         ST_PARITY      = 3;
	localparam int         ST_TX_END      = 2;
	localparam int         ST_RXD_LEVEL   = 0;
	localparam int         CARD_SELECT    = 0;
	localparam int         CARD_INVERSE   = 1;

	// ==========================================================================
	// Reset values
	localparam logic [7:0] FORMAT_RESET   = 8'h00;
	localparam logic [7:0] CONTROL_RESET  = 8'h00;
	localparam logic [7:0] CARD_RESET     = 8'h00;
	localparam logic [7:0] DIVISOR_RESET  = 8'h00;
	localparam logic [7:0] TX_BUF_RESET   = 8'hFF;
	localparam logic [7:0] RX_BUF_RESET   = 8'h00;

	// ==========================================================================
	// Bit timing and frame shape
	localparam logic [3:0] TICK_MID       = 4'h7;
	localparam logic [3:0] TICK_LAST      = 4'hF;
	localparam logic [3:0] TICK_CHECK     = 4'hB;
	localparam logic [3:0] DATA8          = 4'h8;
	localparam logic [3:0] DATA7          = 4'h7;
	localparam logic [3:0] RX_W           = 4'hA;
	localparam int         FRAME_W        = 13;

	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tx_state_type;
	typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_BITS = 4'b0100,
		RX_ERRSIG = 4'b1000} rx_state_type;

	// Line bit order: reversed for MSB first, reversed and inverted for inverse convention
	function automatic logic [7:0] line_order(input logic [7:0] d, input logic msb, input logic inv);
		logic [7:0] r;
		r = d;
		for (int i = 0; i < 8; i++)
			r[i] = d[7 - i];
		if (inv)
			line_order = ~r;
		else if (msb)
			line_order = r;
		else
			line_order = d;
	endfunction

endpackage

// ---- verif/serial_line_model.sv ----
// Purpose: Far-side serial device
// Assumes: one bit lasts BIT_NS
// Notes:   Clock pin toggles only in frames
`timescale 1ns/1ns
module serial_line_model #(parameter int BIT_NS = 1600) (
	// Line side
	input  wire logic        txd,
	output logic             rxd,
	output logic             sck,
	// Bench side
	input  wire logic        go,
	input  wire logic [11:0] pat,
	input  wire logic [3:0]  len,
	output logic      [7:0]  got,
	output logic             got_v,
	output logic             busy
);
	initial
	begin
		rxd = 1;
		sck = 1;
		got = 0;
		got_v = 0;
		busy = 0;
	end
	always #400 sck = busy ? ~sck : 1'b1;
	always @(posedge go)
	begin
		busy = 1;
		for (int i = 0; i < len; i++)
		begin
			rxd = pat[i];
			#(BIT_NS);
		end
		rxd = 1;
		busy = 0;
	end
	always @(negedge txd)
	begin
		got_v = 0;
		#(BIT_NS / 2);
		for (int i = 0; i < 8; i++)
		begin
			#(BIT_NS);
			got[i] = txd;
		end
		got_v = 1;
	end
endmodule // serial_line_model

// ---- verif/serial_port_asserts.sv ----
// Purpose: Bus timing and request relations
// Assumes: one slave, hready tied to hreadyout
// Notes:   Bound into the top module
`timescale 1ns/1ns
module serial_port_asserts
	import serial_port_pkg::*;
(
	// Clock, reset, bus
	input wire logic                 sys_clk,
	input wire logic                 resetn,
	input wire logic                 hsel,
	input wire logic [1:0]           htrans,
	input wire logic                 hwrite,
	input wire logic                 hready,
	input wire logic                 hreadyout,
	input wire logic                 hresp,
	input wire logic [31:0]          hrdata,
	// Pins, requests
	input wire logic [CHAN_COUNT-1:0] txd_out,
	input wire logic [CHAN_COUNT-1:0] sck_oe,
	input wire logic [CHAN_COUNT-1:0][3:0] irq_req,
	input wire logic [CHAN_COUNT-1:0][1:0] dma_req
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence rd_taken;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_read_wait: assert property (rd_taken |=> one_wait) else $error("read wait wrong");
	a_wait_once: assert property (!hreadyout |=> hreadyout) else $error("long wait");
	a_rdata_upper: assert property (rd_taken |=> ##1 hrdata[31:8] == 24'h0) else $error("upper bytes");
	a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
	a_reset_idle: assert property ($rose(resetn) |-> txd_out == '1 && sck_oe == '0 && irq_req == '0)
		else $error("reset state");
	a_dma_tx: assert property (irq_req[0][1] |-> dma_req[0][0]) else $error("tx dma missing");
	a_dma_rx: assert property (irq_req[0][2] |-> dma_req[0][1]) else $error("rx dma missing");
	a_end_empty: assert property (irq_req[0][0] |-> dma_req[0][0]) else $error("end not empty");
endmodule // serial_port_asserts
bind dual_mode_serial_port serial_port_asserts chk (.*);

// ---- verif/tb_top.sv ----
// Purpose: Register and line tests, channel 0
// Assumes: divisor 0, a bit is 16 clocks
// Notes:   Channel 1 lines held idle
`timescale 1ns/1ns
module tb_top
	import serial_port_pkg::*;
;
	logic sys_clk, resetn, hsel, hwrite, go, got_v, busy, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rdat;
	logic [11:0] pat;
	logic [3:0] len;
	logic [7:0] got;
	logic [1:0] sck_out, sck_oe, txd_out;
	logic [1:0][3:0] irq_req;
	logic [1:0][1:0] dma_req;
	wire logic hready;
	wire logic [1:0] rxd_pin, sck_in;
	int n_mismatch, n_tests;
	assign hready = hreadyout;
	assign rxd_pin[1] = 1'b1;
	assign sck_in[1] = 1'b1;
	dual_mode_serial_port dut (.*);
	serial_line_model m (.txd(txd_out[0]), .rxd(rxd_pin[0]), .sck(sck_in[0]), .go, .pat, .len, .got,
		.got_v, .busy);
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic [31:0] a, d, input logic w);
		int n;
		n = 0;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge sys_clk);
		while (hready !== 1'b1 && n++ < 50) @(posedge sys_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge sys_clk);
		while (hready !== 1'b1 && n++ < 50) @(posedge sys_clk);
		rdat = hrdata;
		if (n > 50)
			n_mismatch++;
	endtask
	task automatic poll(input logic [7:0] mk);
		int n;
		n = 0;
		do bus(32'h08, 0, 0);
		while ((rdat[7:0] & mk) == 8'h00 && n++ < 300);
		if (n > 300)
			n_mismatch++;
	endtask
	task automatic snd(input logic [11:0] p, input logic [3:0] l);
		while (busy) @(posedge sys_clk);
		pat <= p;
		len <= l;
		go <= 1;
		@(posedge sys_clk);
		go <= 0;
	endtask
	task automatic catch(input logic [7:0] e);
		int n;
		n = 0;
		while (got_v !== 1'b0 && n++ < 400) @(posedge sys_clk);
		if (n > 400)
			n_mismatch++;
		while (got_v !== 1'b1 && n++ < 2000) @(posedge sys_clk);
		if (n > 2000)
			n_mismatch++;
		chk("line byte", got, e);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		sys_clk = 0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial
	begin
		#3000000;
		n_mismatch++;
		close_out;
	end
	initial
	begin
		{resetn, hsel, hwrite, go, htrans, haddr, hwdata, pat, len} = '0;
		hsize = 3'h2;
		hsel = 1;
		n_mismatch = 0;
		n_tests = 0;
		repeat (4) @(posedge sys_clk);
		resetn <= 1;
		@(posedge sys_clk);
		bus(32'h08, 0, 0);
		chk("status", rdat, 32'h81);
		bus(32'h0C, 32'hAB, 1);
		bus(32'h0C, 0, 0);
		chk("rx buffer", rdat, 32'h00);
		bus(32'h3C, 0, 0);
		chk("unmapped", rdat, 32'h00);
		$display("registers done");
		bus(32'h04, 32'hF4, 1);
		snd({1'b1, 8'h96, 1'b0}, 4'hA);
		chk("requests", irq_req[0], 4'h3);
		chk("clock idle", sck_out, 2'h3);
		bus(32'h10, 32'h5A, 1);
		poll(8'h80);
		bus(32'h10, 32'hC3, 1);
		catch(8'h5A);
		catch(8'hC3);
		poll(8'h40);
		bus(32'h0C, 0, 0);
		chk("rx byte", rdat, 32'h96);
		$display("duplex done");
		snd({1'b1, 8'h11, 1'b0}, 4'hA);
		snd({1'b1, 8'h22, 1'b0}, 4'hA);
		poll(8'h20);
		chk("overrun", rdat & 32'h60, 32'h60);
		bus(32'h0C, 0, 0);
		chk("kept byte", rdat, 32'h11);
		bus(32'h08, 0, 1);
		for (int k = 0; k < 2; k++)
		begin
			bus(32'h00, 32'h20 | (k << 4), 1);
			snd({2'b10, 8'h01, 1'b0}, 4'hB);
			poll(8'h48);
			chk("parity", rdat & 32'h08, k ? 32'h0 : 32'h8);
			bus(32'h0C, 0, 0);
			bus(32'h08, 0, 1);
		end
		$display("errors done");
		bus(32'h00, 32'h00, 1);
		snd(12'h000, 4'hC);
		poll(8'h10);
		chk("break", rdat & 32'h11, 32'h10);
		bus(32'h00, 32'h40, 1);
		poll(8'h04);
		bus(32'h10, 32'h05, 1);
		catch(8'h85);
		bus(32'h00, 32'h04, 1);
		bus(32'h10, 32'h01, 1);
		catch(8'h80);
		$display("formats done");
		close_out;
	end
endmodule // tb_top
